//--- hw/spm_map.vh
// bit positions, reset values and default timing for the serial master port
`ifndef SPM_MAP_VH
`define SPM_MAP_VH
`define SPM_BIT_DONE      7
`define SPM_BIT_MSTEN     6
`define SPM_BIT_MODF      5
`define SPM_BIT_SELHI     3
`define SPM_BIT_SELLO     2
`define SPM_BIT_PEN       0
`define SPM_CTRL_RST      8'h04
`define SPM_BYTE_BITS     8
`define SPM_DIV_DEFAULT   16
`define SPM_CNT_W         3
`define SPM_DIV_W         8
`define SPM_PIN_N         2
`define SPM_PIN_IDLE      2'h2
`endif

//--- hw/spm_shifter.v
// eight-bit full-duplex shifter with serial clock generation
`timescale 1ns/1ps
`default_nettype none
`include "spm_map.vh"
module spm_shifter #(
    parameter HALF_DIV = `SPM_DIV_DEFAULT
) (
    // clock and reset
    input  wire       clock_i,
    input  wire       rst_n_i,
    // control
    input  wire       start_i,
    input  wire [7:0] tx_byte_i,
    input  wire       abort_i,
    input  wire       miso_i,
    // results
    output reg        busy_o,
    output reg        done_o,
    output reg  [7:0] rx_byte_o,
    output reg        sck_o,
    output wire       mosi_o
);
    reg [7:0]             shift_r;
    reg [`SPM_CNT_W-1:0]  bit_r;
    reg [`SPM_DIV_W-1:0]  div_r;
    reg                   rx_bit_r;
    // end counts held as integers, then cut to the counter widths
    localparam integer DIV_LAST_I = HALF_DIV - 1;
    localparam integer BIT_LAST_I = `SPM_BYTE_BITS - 1;
    localparam [`SPM_DIV_W-1:0] DIV_LAST = DIV_LAST_I[`SPM_DIV_W-1:0];
    localparam [`SPM_CNT_W-1:0] BIT_LAST = BIT_LAST_I[`SPM_CNT_W-1:0];

    assign mosi_o = shift_r[7]; // msb leaves first

    // sample on rising sck, shift on falling sck
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            rx_byte_o <= 8'h00;
            sck_o     <= 1'b0;
            shift_r   <= 8'h00;
            bit_r     <= {`SPM_CNT_W{1'b0}};
            div_r     <= {`SPM_DIV_W{1'b0}};
            rx_bit_r  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                busy_o <= 1'b0;
                sck_o  <= 1'b0;
            end else if (!busy_o) begin
                if (start_i) begin
                    shift_r <= tx_byte_i;
                    busy_o  <= 1'b1;
                    bit_r   <= {`SPM_CNT_W{1'b0}};
                    div_r   <= {`SPM_DIV_W{1'b0}};
                end
            end else if (div_r == DIV_LAST) begin
                div_r <= {`SPM_DIV_W{1'b0}};
                sck_o <= ~sck_o;
                if (!sck_o) begin
                    rx_bit_r <= miso_i;
                end else begin
                    // the sampled bit joins the shifter on the fall, so
                    // the last outgoing bit is not overwritten early
                    if (bit_r == BIT_LAST) begin
                        busy_o    <= 1'b0;
                        done_o    <= 1'b1;
                        rx_byte_o <= {shift_r[6:0], rx_bit_r};
                    end else begin
                        shift_r <= {shift_r[6:0], rx_bit_r};
                    end
                    bit_r <= bit_r + 1'b1;
                end
            end else begin
                div_r <= div_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/spm_master_port.v
// serial peripheral master port: control bits, buffers, select handling
// Operation
// - master enable bit starts master operation; here the port enable bit must be set as well
// - data write goes to transmit buffer only while master enable bit set
// - empty shifter loads buffer, starts transfer
// - shift out on mosi, drive sck
// - set done flag at transfer end
// - interrupt when done flag set, enabled
// - full duplex, one flag for both
// - received byte shifts in msb first
// - full byte goes to receive buffer
// - select bits 01 give multi-master mode
// - low select clears enables, sets fault
// - fault interrupt when enabled
// - select bits 00: three-wire, select unused
// - high select bit: drive select output
// - select output follows low select bit
`timescale 1ns/1ps
`default_nettype none
`include "spm_map.vh"
module spm_master_port #(
    parameter HALF_DIV = `SPM_DIV_DEFAULT
) (
    // clock and reset
    input  wire       clock_i,
    input  wire       rst_n_i,
    // software control writes
    input  wire       ctrl_wr_i,
    input  wire [7:0] ctrl_wdata_i,
    input  wire       data_wr_i,
    input  wire [7:0] data_wdata_i,
    input  wire       done_int_en_i,
    input  wire       fault_int_en_i,
    // software reads
    output wire [7:0] ctrl_rdata_o,
    output reg  [7:0] data_rdata_o,
    output wire       tx_buf_full_o,
    output wire       irq_o,
    // serial pins
    output wire       sck_o,
    output wire       mosi_o,
    input  wire       miso_i,
    input  wire       sel_i,
    output wire       sel_o,
    output wire       sel_oe_o
);
    localparam             PIN_N    = `SPM_PIN_N;
    localparam [PIN_N-1:0] PIN_IDLE = `SPM_PIN_IDLE;
    localparam [7:0]       CTRL_RST = `SPM_CTRL_RST;
    // incoming pins: bit 0 data from the slave, bit 1 select
    wire [PIN_N-1:0] pin_raw;
    wire [PIN_N-1:0] pin_sync;
    wire             miso_sync;
    wire             sel_sync;
    // software write data split into control fields
    wire             wr_done_bit;
    wire             wr_master_bit;
    wire             wr_fault_bit;
    wire             wr_sel_hi_bit;
    wire             wr_sel_lo_bit;
    wire             wr_port_bit;
    // control and status bits
    reg        master_enable_bit_r;
    reg        port_enable_bit_r;
    reg        transfer_done_flag_r;
    reg        mode_fault_flag_r;
    reg        select_mode_high_bit_r;
    reg        select_mode_low_bit_r;
    reg  [7:0] tx_buf_r;
    reg        tx_full_r;
    // shifter handshake and decode nets
    wire       busy;
    wire       done;
    wire [7:0] rx_byte;
    wire       active;
    wire       fault;
    wire       start;
    wire       multi_mode;

    // two flip-flops per pin before any logic; only the second is read,
    // and each resets to its pin's idle level so no false fault follows
    assign pin_raw = {sel_i, miso_i};
    genvar g;
    generate
        for (g = 0; g < PIN_N; g = g + 1) begin : g_sync
            reg first_r;
            reg second_r;
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    first_r  <= PIN_IDLE[g];
                    second_r <= PIN_IDLE[g];
                end else begin
                    first_r  <= pin_raw[g];
                    second_r <= first_r;
                end
            end
            assign pin_sync[g] = second_r;
        end
    endgenerate
    assign miso_sync = pin_sync[0];
    assign sel_sync  = pin_sync[1];

    // mode decode, fault detect and transfer start
    assign multi_mode = !select_mode_high_bit_r &&
                        select_mode_low_bit_r;
    assign fault  = multi_mode && !sel_sync;
    assign active = master_enable_bit_r && port_enable_bit_r;
    assign start  = active && tx_full_r && !busy && !fault;

    // write data fields
    assign wr_done_bit   = ctrl_wdata_i[`SPM_BIT_DONE];
    assign wr_master_bit = ctrl_wdata_i[`SPM_BIT_MSTEN];
    assign wr_fault_bit  = ctrl_wdata_i[`SPM_BIT_MODF];
    assign wr_sel_hi_bit = ctrl_wdata_i[`SPM_BIT_SELHI];
    assign wr_sel_lo_bit = ctrl_wdata_i[`SPM_BIT_SELLO];
    assign wr_port_bit   = ctrl_wdata_i[`SPM_BIT_PEN];

    // done flag: a finishing transfer beats a software clear
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transfer_done_flag_r <= CTRL_RST[`SPM_BIT_DONE];
        end else if (done) begin
            transfer_done_flag_r <= 1'b1;
        end else if (ctrl_wr_i) begin
            transfer_done_flag_r <= wr_done_bit;
        end
    end

    // enables: a mode fault beats a software write in the same cycle,
    // so in multi-master mode the port cannot be re-enabled while the select pin stays low
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            master_enable_bit_r <= CTRL_RST[`SPM_BIT_MSTEN];
            port_enable_bit_r   <= CTRL_RST[`SPM_BIT_PEN];
        end else if (fault) begin
            master_enable_bit_r <= 1'b0;
            port_enable_bit_r   <= 1'b0;
        end else if (ctrl_wr_i) begin
            master_enable_bit_r <= wr_master_bit;
            port_enable_bit_r   <= wr_port_bit;
        end
    end

    // mode fault flag, sticky until software writes a zero
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_fault_flag_r <= CTRL_RST[`SPM_BIT_MODF];
        end else if (fault) begin
            mode_fault_flag_r <= 1'b1;
        end else if (ctrl_wr_i) begin
            mode_fault_flag_r <= wr_fault_bit;
        end
    end

    // select mode bits, written by software only;
    // reset leaves the port in multi-master mode
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            select_mode_high_bit_r <= CTRL_RST[`SPM_BIT_SELHI];
            select_mode_low_bit_r  <= CTRL_RST[`SPM_BIT_SELLO];
        end else if (ctrl_wr_i) begin
            select_mode_high_bit_r <= wr_sel_hi_bit;
            select_mode_low_bit_r  <= wr_sel_lo_bit;
        end
    end

    // transmit buffer; a write in the start cycle refills it
    // after the old byte has gone to the shifter
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_buf_r  <= 8'h00;
            tx_full_r <= 1'b0;
        end else begin
            if (start)
                tx_full_r <= 1'b0;
            if (data_wr_i && master_enable_bit_r) begin
                tx_buf_r  <= data_wdata_i;
                tx_full_r <= 1'b1;
            end
        end
    end

    // receive buffer, updated as each byte completes
    // and held until the next byte replaces it
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            data_rdata_o <= 8'h00;
        else if (done)
            data_rdata_o <= rx_byte;
    end

    // eight-bit shifter; a mode fault stops it at once
    spm_shifter #(
        .HALF_DIV (HALF_DIV)
    ) u_shift (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .start_i   (start),
        .tx_byte_i (tx_buf_r),
        .abort_i   (fault),
        .miso_i    (miso_sync),
        .busy_o    (busy),
        .done_o    (done),
        .rx_byte_o (rx_byte),
        .sck_o     (sck_o),
        .mosi_o    (mosi_o)
    );

    // control read-back; bit 1 shows busy, bit 4 reads zero
    assign ctrl_rdata_o = {transfer_done_flag_r, master_enable_bit_r,
                           mode_fault_flag_r, 1'b0, select_mode_high_bit_r,
                           select_mode_low_bit_r, busy, port_enable_bit_r};
    // buffer holds a byte not yet moved to the shifter
    assign tx_buf_full_o = tx_full_r;
    // interrupt request from either flag
    assign irq_o = (done_int_en_i && transfer_done_flag_r) ||
                   (fault_int_en_i && mode_fault_flag_r);
    // select pin drive, unused in three-wire mode
    assign sel_oe_o = select_mode_high_bit_r;
    assign sel_o    = select_mode_high_bit_r &&
                      select_mode_low_bit_r;
endmodule
`default_nettype wire

//--- verif/spm_port_assertions.sv
// concurrent checks on the serial master port pins and control bits
`timescale 1ns/1ps
`default_nettype none
module spm_port_chk (
    // clock and reset
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    // watched ports
    input wire logic       done_int_en_i,
    input wire logic       fault_int_en_i,
    input wire logic [7:0] ctrl_rdata_o,
    input wire logic       tx_buf_full_o,
    input wire logic       irq_o,
    input wire logic       sck_o,
    input wire logic       mosi_o,
    input wire logic       sel_o,
    input wire logic       sel_oe_o
);
    logic [3:0] edges_r;
    // count sck rises since the transfer went busy
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edges_r <= 4'h0;
        end else if ($rose(ctrl_rdata_o[1])) begin
            edges_r <= 4'h0;
        end else if ($rose(sck_o)) begin
            edges_r <= edges_r + 4'h1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // buffer full, both enables set, shifter idle
    sequence s_ready;
        tx_buf_full_o && ctrl_rdata_o[6] && ctrl_rdata_o[0] && !ctrl_rdata_o[1];
    endsequence
    sequence s_busy;
        ##[1:3] ctrl_rdata_o[1];
    endsequence
    chk_start_busy: assert property (s_ready |-> s_busy)
        else $error("transfer did not start");
    chk_done_count: assert property ($rose(ctrl_rdata_o[7]) |-> edges_r == 4'h8)
        else $error("done without eight clocks");
    chk_sck_idle: assert property (!ctrl_rdata_o[1] && !$past(ctrl_rdata_o[1]) |-> !sck_o)
        else $error("sck moved while idle");
    chk_mosi_hold: assert property (sck_o && $past(sck_o) |-> $stable(mosi_o))
        else $error("mosi changed while sck high");
    chk_fault_off: assert property ($rose(ctrl_rdata_o[5]) |-> !ctrl_rdata_o[6] && !ctrl_rdata_o[0])
        else $error("fault left enables set");
    chk_irq_map: assert property (irq_o == ((ctrl_rdata_o[7] && done_int_en_i) || (ctrl_rdata_o[5] && fault_int_en_i)))
        else $error("irq mismatch");
    chk_sel_level: assert property (ctrl_rdata_o[3] |-> sel_o == ctrl_rdata_o[2])
        else $error("select level wrong");
    chk_sel_drive: assert property (sel_oe_o == ctrl_rdata_o[3])
        else $error("select enable wrong");
endmodule
bind spm_master_port spm_port_chk i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .done_int_en_i(done_int_en_i), .fault_int_en_i(fault_int_en_i),
    .ctrl_rdata_o(ctrl_rdata_o), .tx_buf_full_o(tx_buf_full_o), .irq_o(irq_o),
    .sck_o(sck_o), .mosi_o(mosi_o), .sel_o(sel_o), .sel_oe_o(sel_oe_o));
`default_nettype wire

//--- verif/spm_slave_model.sv
// behavioural mode 0 slave on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
    // serial pins
    input wire logic       sck_i,
    input wire logic       mosi_i,
    output var logic       miso_o,
    // bench side
    input wire logic       load_i,
    input wire logic [7:0] tx_i,
    output var logic [7:0] rx_o
);
    logic [7:0] sh_r;
    // reply msb first, shift on fall, fill with a changing pattern
    assign miso_o = sh_r[7];
    always @(posedge load_i or negedge sck_i) begin
        if (load_i) sh_r <= tx_i;
        else sh_r <= {sh_r[6:0], ~sh_r[0]};
    end
    // capture master data on the rise
    always @(posedge sck_i) rx_o <= {rx_o[6:0], mosi_i};
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the serial master port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clock_i, rst_n_i, ctrl_wr_i, data_wr_i, ld, sel_i, miso;
    logic       done_int_en_i, fault_int_en_i, tx_buf_full_o, irq_o;
    logic       sck_o, mosi_o, sel_o, sel_oe_o;
    logic [7:0] ctrl_wdata_i, data_wdata_i, ctrl_rdata_o, data_rdata_o;
    logic [7:0] s_tx, s_rx, q[$];
    logic [15:0] rnd;
    int         errors, total_checks, n;
    // 200 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    spm_master_port #(.HALF_DIV(16)) i_dut (.clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .data_wr_i(data_wr_i),
        .data_wdata_i(data_wdata_i), .done_int_en_i(done_int_en_i),
        .fault_int_en_i(fault_int_en_i), .ctrl_rdata_o(ctrl_rdata_o),
        .data_rdata_o(data_rdata_o), .tx_buf_full_o(tx_buf_full_o), .irq_o(irq_o),
        .sck_o(sck_o), .mosi_o(mosi_o), .miso_i(miso), .sel_i(sel_i),
        .sel_o(sel_o), .sel_oe_o(sel_oe_o));
    spm_slave_model i_slave (.sck_i(sck_o), .mosi_i(mosi_o), .miso_o(miso),
        .load_i(ld), .tx_i(s_tx), .rx_o(s_rx));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one-cycle write pulses
    task automatic wctl(input logic [7:0] v);
        @(negedge clock_i) ctrl_wdata_i = v;
        ctrl_wr_i = 1'b1;
        @(negedge clock_i) ctrl_wr_i = 1'b0;
    endtask
    task automatic wdat(input logic [7:0] v);
        @(negedge clock_i) data_wdata_i = v;
        data_wr_i = 1'b1;
        @(negedge clock_i) data_wr_i = 1'b0;
    endtask
    task automatic wait_done;
        int k;
        for (k = 0; k < 400 && ctrl_rdata_o[7] !== 1'b1; k++) @(negedge clock_i);
        if (ctrl_rdata_o[7] !== 1'b1) begin
            errors++;
            close_out();
        end
    endtask
    // main sequence
    initial begin
        {rst_n_i, ctrl_wr_i, data_wr_i, ld, done_int_en_i, fault_int_en_i} = 6'h00;
        {sel_i, ctrl_wdata_i, data_wdata_i, s_tx} = {1'b1, 24'h000000};
        {errors, total_checks, rnd} = {32'h0, 32'h0, 16'h321B};
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        chk(ctrl_rdata_o, 8'h04);
        wdat(8'hA5);
        chk({7'h00, tx_buf_full_o}, 8'h00);
        wctl(8'h45);
        done_int_en_i = 1'b1;
        for (n = 0; n < 3; n++) begin
            rnd = lfsr(rnd);
            s_tx = rnd[15:8];
            @(negedge clock_i) ld = 1'b1;
            @(negedge clock_i) ld = 1'b0;
            wdat(rnd[7:0]);
            chk({7'h00, tx_buf_full_o}, 8'h01);
            q.push_back(rnd[7:0]);
            wait_done();
            chk(data_rdata_o, s_tx);
            chk(s_rx, q.pop_front());
            chk(ctrl_rdata_o & 8'hFD, 8'hC5);
            chk({7'h00, irq_o}, 8'h01);
            wctl(8'h45);
        end
        {done_int_en_i, fault_int_en_i, sel_i} = 3'h2;
        repeat (6) @(negedge clock_i);
        chk(ctrl_rdata_o, 8'h24);
        chk({7'h00, irq_o}, 8'h01);
        sel_i = 1'b1;
        wdat(8'h3C);
        chk({7'h00, tx_buf_full_o}, 8'h00);
        wctl(8'h08);
        chk({6'h00, sel_oe_o, sel_o}, 8'h02);
        wctl(8'h0C);
        chk({6'h00, sel_oe_o, sel_o}, 8'h03);
        wctl(8'h00);
        chk({7'h00, sel_oe_o}, 8'h00);
        wctl(8'h41);
        sel_i = 1'b0;
        repeat (6) @(negedge clock_i);
        chk(ctrl_rdata_o, 8'h41);
        chk({7'h00, irq_o}, 8'h00);
        s_tx = 8'h96;
        @(negedge clock_i) ld = 1'b1;
        @(negedge clock_i) ld = 1'b0;
        wdat(8'h5A);
        wait_done();
        chk(data_rdata_o, 8'h96);
        chk(s_rx, 8'h5A);
        chk(ctrl_rdata_o & 8'hFD, 8'hC1);
        sel_i = 1'b1;
        close_out();
    end
endmodule
`default_nettype wire
